// file: ssrd_port.v
// Synchronous serial port, receive and duplex modes, with shift clock pin
// Assumes software strobes are one-cycle pulses on clk; sclk pin is asynchronous
//
// What this block does
// - Mode 01 receive, mode 10 duplex
// - Active flag rises on a falling clock edge
// - Sample input on rising edge, chosen order
// - Shift flag spans first to eighth falling edge
// - Full byte: buffer load, full flag, interrupt
// - Internal clock starts within one serial period
// - Buffer read clears full flag when no receive error stands
// - Internal receive parks clock until read
// - Unread full buffer makes receive error
// - Receive error discards bits, keeps contents
// - Error reads: old byte then captured shift
// - Error clear clears full; stop after byte
// - Run cleared: finish byte, drop active, output high
// - Inhibit halts and reinitialises all but shift, capture, divider and external clock edge state
// - No further interrupts while error stands
// - Duplex: drive on falling, sample on rising
// - Duplex: free flag at rising edge, interrupt after byte
// - External duplex: first falling edge loads transmit
// - Internal duplex parks until read and write
// - Transmit error: flag, output high, interrupt later
// - Clock select 111 takes external clock
// - Falling edge transmits, rising edge receives
`timescale 1ns/100ps
`include "ssrd_consts.vh"
module ssrd_port
#(
   parameter DIV_HALF = 4
)
(
   input  wire       clk,
   input  wire       rst,
   input  wire [1:0] transferModeField,
   input  wire [2:0] clockSelect,
   input  wire       bitOrderSelect,
   input  wire       runSet,
   input  wire       runClear,
   input  wire       inhibitBit,
   input  wire       rxErrorClear,
   input  wire       rxBufferRead,
   input  wire       txBufferWrite,
   input  wire [7:0] txWriteData,
   input  wire       txFifoValid,
   input  wire [7:0] txFifoData,
   output wire       txFifoReady,
   output reg        runBit_q,
   output reg  [7:0] receiveBuffer_q,
   output reg        transferActiveFlag_q,
   output reg        shiftInProgressFlag_q,
   output reg        receiveFullFlag_q,
   output reg        transmitBufferFreeFlag_q,
   output reg        receiveErrorFlag_q,
   output reg        transmitErrorFlag_q,
   output reg        serialInterruptRequest_q,
   input  wire       sclkIn,
   output reg        sclkOut_q,
   output reg        sclkOe_q,
   input  wire       serialIn,
   output reg        serialOut_q
);
   //////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edge detection
   reg  [2:0] sclkSync_q;
   reg  [2:0] sinSync_q;
   reg        sclkLevel_q;
   reg        sinLevel_q;
   wire       extClk;
   wire       duplex;
   wire       rxMode;
   wire       fall;
   wire       rise;
   wire       sinFiltered = (sinSync_q[1] == sinSync_q[2]) ? sinSync_q[2] : sinLevel_q;
   reg        fifoReady_q;

   assign extClk = (clockSelect == `SSRD_CLK_EXT);
   assign duplex = (transferModeField == `SSRD_MODE_DUPLEX);
   assign rxMode = (transferModeField == `SSRD_MODE_RX) | duplex;

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sclkSync_q  <= 3'h7;
         sinSync_q   <= 3'h7;
         sclkLevel_q <= 1'b1;
         sinLevel_q  <= 1'b1;
      end
      else
      begin
         sclkSync_q <= {sclkSync_q[1:0], sclkIn};
         sinSync_q  <= {sinSync_q[1:0], serialIn};
         if (sclkSync_q[1] == sclkSync_q[2])
            sclkLevel_q <= sclkSync_q[2];
         sinLevel_q <= sinFiltered;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Internal clock generator and edge selection
   reg [7:0] divCnt_q;
   reg       intFall;
   reg       intRise;
   wire      divTick;
   reg       extPrev_q;
   wire      extFall;
   wire      extRise;
   wire      waitRelease;
   reg       rdDone_q;
   reg       wrDone_q;
   reg       parked_q;

   assign divTick = (divCnt_q == DIV_HALF[7:0] - 8'h01);
   assign extFall = extClk & extPrev_q & ~sclkLevel_q;
   assign extRise = extClk & ~extPrev_q & sclkLevel_q;

   // Duplex needs both accesses, receive needs only the read
   assign waitRelease = duplex ? (rdDone_q & wrDone_q) : rdDone_q;

   always @*
   begin
      intFall = 1'b0;
      intRise = 1'b0;
      if (!extClk && divTick && sclkOe_q && !parked_q)
      begin
         intFall = sclkOut_q;
         intRise = ~sclkOut_q;
      end
   end

   assign fall = extClk ? extFall : intFall;
   assign rise = extClk ? extRise : intRise;

   //////////////////////////////////////////////////////////////////////
   // Shift engine
   reg  [7:0] shiftReg_q;
   reg  [7:0] txBuf_q;
   reg        txLoaded_q;
   reg  [3:0] bitCnt_q;
   reg  [7:0] capture_q;
   reg        captureValid_q;
   reg        intEnabled_q;
   wire [7:0] rxShifted;
   wire       byteDone;
   wire       canRun;

   assign rxShifted = bitOrderSelect ? {sinFiltered, shiftReg_q[7:1]}
                                     : {shiftReg_q[6:0], sinFiltered};
   assign byteDone  = rise & transferActiveFlag_q & (bitCnt_q == `SSRD_BITS - 4'h1);
   assign canRun    = runBit_q & rxMode & (!duplex | txLoaded_q | extClk);
   assign txFifoReady = fifoReady_q;

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         divCnt_q                 <= 8'h00;
         extPrev_q                <= 1'b1;
         sclkOut_q                <= `SSRD_IDLE_LEVEL;
         sclkOe_q                 <= 1'b0;
         serialOut_q              <= `SSRD_IDLE_LEVEL;
         runBit_q                 <= 1'b0;
         shiftReg_q               <= `SSRD_BYTE_RESET;
         txBuf_q                  <= `SSRD_BYTE_RESET;
         txLoaded_q               <= 1'b0;
         bitCnt_q                 <= 4'h0;
         capture_q                <= `SSRD_BYTE_RESET;
         captureValid_q           <= 1'b0;
         receiveBuffer_q          <= `SSRD_BYTE_RESET;
         transferActiveFlag_q     <= 1'b0;
         shiftInProgressFlag_q    <= 1'b0;
         receiveFullFlag_q        <= 1'b0;
         transmitBufferFreeFlag_q <= 1'b1;
         receiveErrorFlag_q       <= 1'b0;
         transmitErrorFlag_q      <= 1'b0;
         serialInterruptRequest_q <= 1'b0;
         intEnabled_q             <= 1'b1;
         rdDone_q                 <= 1'b0;
         wrDone_q                 <= 1'b0;
         parked_q                 <= 1'b0;
         fifoReady_q              <= 1'b0;
      end
      else if (inhibitBit)
      begin
         // Immediate halt and reinitialisation
         runBit_q                 <= 1'b0;
         sclkOut_q                <= `SSRD_IDLE_LEVEL;
         sclkOe_q                 <= 1'b0;
         serialOut_q              <= `SSRD_IDLE_LEVEL;
         txBuf_q                  <= `SSRD_BYTE_RESET;
         txLoaded_q               <= 1'b0;
         bitCnt_q                 <= 4'h0;
         captureValid_q           <= 1'b0;
         receiveBuffer_q          <= `SSRD_BYTE_RESET;
         transferActiveFlag_q     <= 1'b0;
         shiftInProgressFlag_q    <= 1'b0;
         receiveFullFlag_q        <= 1'b0;
         transmitBufferFreeFlag_q <= 1'b1;
         receiveErrorFlag_q       <= 1'b0;
         transmitErrorFlag_q      <= 1'b0;
         serialInterruptRequest_q <= 1'b0;
         intEnabled_q             <= 1'b1;
         rdDone_q                 <= 1'b0;
         wrDone_q                 <= 1'b0;
         parked_q                 <= 1'b0;
         fifoReady_q              <= 1'b0;
      end
      else
      begin
         serialInterruptRequest_q <= 1'b0;
         extPrev_q <= sclkLevel_q;
         divCnt_q  <= divTick ? 8'h00 : divCnt_q + 8'h01;
         if (runSet)
            runBit_q <= 1'b1;
         else if (runClear)
            runBit_q <= 1'b0;

         // Transmit buffer from software strobe or from the FIFO
         fifoReady_q <= ~txLoaded_q & ~txBufferWrite & ~fifoReady_q;
         if (txBufferWrite)
         begin
            txBuf_q                  <= txWriteData;
            txLoaded_q               <= 1'b1;
            transmitBufferFreeFlag_q <= 1'b0;
         end
         else if (fifoReady_q && txFifoValid)
         begin
            txBuf_q                  <= txFifoData;
            txLoaded_q               <= 1'b1;
            transmitBufferFreeFlag_q <= 1'b0;
         end
         if (txBufferWrite || (fifoReady_q && txFifoValid))
            wrDone_q <= 1'b1;

         // Buffer reads: error path returns captured shift on second read
         if (rxBufferRead)
         begin
            rdDone_q <= 1'b1;
            if (!receiveErrorFlag_q)
               receiveFullFlag_q <= 1'b0;
            if (receiveErrorFlag_q && captureValid_q)
            begin
               receiveBuffer_q <= capture_q;
               captureValid_q  <= 1'b0;
            end
         end
         if (rxErrorClear)
         begin
            receiveErrorFlag_q <= 1'b0;
            receiveFullFlag_q  <= 1'b0;
            intEnabled_q       <= 1'b1;
         end

         // Internal clock: park high, start within one period after release
         if (!extClk)
         begin
            if (!transferActiveFlag_q && canRun && !sclkOe_q)
            begin
               sclkOe_q <= 1'b1;
               parked_q <= 1'b0;
            end
            else if (parked_q && waitRelease && runBit_q)
            begin
               sclkOe_q <= 1'b1;
               parked_q <= 1'b0;
               rdDone_q <= 1'b0;
               wrDone_q <= 1'b0;
            end
            else if (parked_q && !runBit_q)
            begin
               sclkOe_q             <= 1'b0;
               parked_q             <= 1'b0;
               transferActiveFlag_q <= 1'b0;
               serialOut_q          <= `SSRD_IDLE_LEVEL;
            end
            if (divTick && sclkOe_q && !parked_q)
               sclkOut_q <= ~sclkOut_q;
         end
         else
         begin
            sclkOe_q  <= 1'b0;
            sclkOut_q <= `SSRD_IDLE_LEVEL;
         end

         // Leading edge: start byte, drive output bit
         if (fall && (transferActiveFlag_q || canRun))
         begin
            transferActiveFlag_q <= 1'b1;
            if (bitCnt_q == 4'h0)
            begin
               shiftInProgressFlag_q <= 1'b1;
               if (duplex && txLoaded_q)
               begin
                  shiftReg_q  <= txBuf_q;
                  txLoaded_q  <= 1'b0;
                  serialOut_q <= bitOrderSelect ? txBuf_q[0] : txBuf_q[7];
               end
               else if (duplex)
               begin
                  transmitErrorFlag_q <= 1'b1;
                  serialOut_q         <= `SSRD_IDLE_LEVEL;
               end
            end
            else
            begin
               if (duplex && !transmitErrorFlag_q)
                  serialOut_q <= bitOrderSelect ? shiftReg_q[0] : shiftReg_q[7];
               if (bitCnt_q == `SSRD_BITS - 4'h1)
                  shiftInProgressFlag_q <= 1'b0;
            end
         end

         // Trailing edge: sample input bit
         if (rise && transferActiveFlag_q)
         begin
            if (bitCnt_q == 4'h0 && duplex && !transmitErrorFlag_q)
               transmitBufferFreeFlag_q <= 1'b1;
            if (!receiveErrorFlag_q)
               shiftReg_q <= rxShifted;
            bitCnt_q <= byteDone ? 4'h0 : bitCnt_q + 4'h1;
         end

         if (byteDone)
         begin
            shiftInProgressFlag_q <= 1'b0;
            if (!receiveErrorFlag_q && receiveFullFlag_q && !rxBufferRead)
            begin
               receiveErrorFlag_q <= 1'b1;
               capture_q          <= rxShifted;
               captureValid_q     <= 1'b1;
               if (intEnabled_q)
                  serialInterruptRequest_q <= 1'b1;
               intEnabled_q <= 1'b0;
            end
            else if (!receiveErrorFlag_q)
            begin
               receiveBuffer_q   <= rxShifted;
               receiveFullFlag_q <= 1'b1;
               if (intEnabled_q)
                  serialInterruptRequest_q <= 1'b1;
               if (transmitErrorFlag_q)
                  intEnabled_q <= 1'b0;
            end
            if (!runBit_q)
            begin
               transferActiveFlag_q <= 1'b0;
               serialOut_q          <= `SSRD_IDLE_LEVEL;
               sclkOe_q             <= 1'b0;
               sclkOut_q            <= `SSRD_IDLE_LEVEL;
            end
            else if (!extClk)
            begin
               // Auto wait: park clock high until released
               sclkOe_q  <= 1'b1;
               sclkOut_q <= `SSRD_IDLE_LEVEL;
               parked_q  <= 1'b1;
               rdDone_q  <= rxBufferRead;
               wrDone_q  <= txLoaded_q;
            end
         end
      end
   end
endmodule

// file: ssrd_consts.vh
// Constants for the synchronous serial receive / duplex port
// Assumes inclusion by bare name from the design files
`ifndef SSRD_CONSTS_VH
`define SSRD_CONSTS_VH
`define SSRD_MODE_TX      2'h0
`define SSRD_MODE_RX      2'h1
`define SSRD_MODE_DUPLEX  2'h2
`define SSRD_CLK_EXT      3'h7
`define SSRD_BITS         4'h8
`define SSRD_BYTE_RESET   8'h00
`define SSRD_IDLE_LEVEL   1'h1
`define SSRD_CLK_PER_NS   50
`define SSRD_LINK_MIN_NS  200
`define SSRD_FIFO_DEPTH   8
`define SSRD_FIFO_WIDTH   8
`endif

// file: ssrd_fifo.v
// Word FIFO with valid/ready on both sides, flip-flop storage
// Assumes a single clock and active-high asynchronous reset
`timescale 1ns/100ps
module ssrd_fifo
#(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW    = 3
)
(
   input  wire             clk,
   input  wire             rst,
   input  wire             flush,
   input  wire [WIDTH-1:0] inData,
   input  wire             inValid,
   output wire             inReady,
   output wire [WIDTH-1:0] outData,
   output wire             outValid,
   input  wire             outReady
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wrPtr_q;
   reg [AW-1:0]    rdPtr_q;
   reg [AW:0]      count_q;
   wire            push;
   wire            pop;
   integer         i;

   assign inReady  = (count_q != DEPTH[AW:0]);
   assign outValid = (count_q != {(AW+1){1'b0}});
   assign outData  = mem[rdPtr_q];
   assign push     = inValid & inReady;
   assign pop      = outValid & outReady;

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wrPtr_q <= {AW{1'b0}};
         rdPtr_q <= {AW{1'b0}};
         count_q <= {(AW+1){1'b0}};
         for (i = 0; i < DEPTH; i = i + 1)
            mem[i] <= {WIDTH{1'b0}};
      end
      else if (flush)
      begin
         wrPtr_q <= {AW{1'b0}};
         rdPtr_q <= {AW{1'b0}};
         count_q <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
         begin
            mem[wrPtr_q] <= inData;
            wrPtr_q      <= (wrPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_q + 1'b1;
         end
         if (pop)
            rdPtr_q <= (rdPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_q + 1'b1;
         if (push && !pop)
            count_q <= count_q + 1'b1;
         else if (pop && !push)
            count_q <= count_q - 1'b1;
      end
   end
endmodule

// file: ssrd_port_monitor.sv
// Checker for the serial port: flag, interrupt and pin relations
// Assumes binding to ssrd_port; clk domain, rst async active high
`timescale 1ns/100ps
`include "ssrd_consts.vh"
module ssrd_port_monitor
#(
   parameter DIV_HALF = 4
)
(
   input wire       clk,
   input wire       rst,
   input wire [1:0] transferModeField,
   input wire [2:0] clockSelect,
   input wire       rxBufferRead,
   input wire       inhibitBit,
   input wire       runBit_q,
   input wire [7:0] receiveBuffer_q,
   input wire       transferActiveFlag_q,
   input wire       receiveFullFlag_q,
   input wire       receiveErrorFlag_q,
   input wire       transmitErrorFlag_q,
   input wire       serialInterruptRequest_q,
   input wire       sclkOe_q,
   input wire       serialOut_q
);
   localparam int START_MAX = 2 * DIV_HALF + 8;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////////
   a_irq_pulse: assert property (serialInterruptRequest_q |=> !serialInterruptRequest_q)
      else $error("interrupt longer than one cycle");
   a_full_irq: assert property ($rose(receiveFullFlag_q) |-> ##[0:1] serialInterruptRequest_q)
      else $error("full flag without interrupt");
   a_read_clears: assert property (rxBufferRead && !receiveErrorFlag_q |=> !receiveFullFlag_q)
      else $error("read left full flag set");
   a_err_quiet: assert property (receiveErrorFlag_q && $past(receiveErrorFlag_q, 3)
      |-> !serialInterruptRequest_q)
      else $error("interrupt while error stands");
   a_err_frozen: assert property (receiveErrorFlag_q && $past(receiveErrorFlag_q) && !$past(rxBufferRead)
      |-> $stable(receiveBuffer_q))
      else $error("buffer changed during error");
   a_inhibit_init: assert property (inhibitBit |=> !runBit_q && !transferActiveFlag_q && !receiveFullFlag_q
      && !receiveErrorFlag_q && !transmitErrorFlag_q && receiveBuffer_q == 8'h00)
      else $error("inhibit did not reinitialise");
   a_transmit_error_flag_high: assert property (transmitErrorFlag_q && $past(transmitErrorFlag_q) |-> serialOut_q)
      else $error("output low during transmit error");
   a_ext_no_drive: assert property (clockSelect == `SSRD_CLK_EXT && $past(clockSelect, 4) == `SSRD_CLK_EXT
      |-> !sclkOe_q)
      else $error("clock driven with external select");
   a_clock_starts: assert property ($rose(runBit_q) && clockSelect != `SSRD_CLK_EXT
      && transferModeField == `SSRD_MODE_RX |-> ##[0:START_MAX] sclkOe_q)
      else $error("internal clock did not start");
   a_stop_high: assert property (!transferActiveFlag_q && $past(!transferActiveFlag_q)
      && transferModeField == `SSRD_MODE_DUPLEX |-> serialOut_q)
      else $error("output not high while stopped");
   c_rx_err: cover property ($rose(receiveErrorFlag_q));
   c_tx_err: cover property ($rose(transmitErrorFlag_q));
   c_duplex: cover property (serialInterruptRequest_q && transferModeField == `SSRD_MODE_DUPLEX);
endmodule

// file: ssrd_far_model.sv
// Far-side serial device: shifts a byte in and out, can clock a frame
// Assumes sclkLine is the resolved clock pin, idling high between frames
`timescale 1ns/100ps
module ssrd_far_model
(
   input  wire logic       sclkLine,
   input  wire logic       bitOrder,
   input  wire logic       serialOut,
   output logic            serialIn,
   output logic            extSclk,
   output logic [7:0]      rxByte
);
   logic [7:0] txByte;
   logic [2:0] cnt;
   initial
   begin
      serialIn = 1'b1;
      extSclk = 1'b1;
      txByte = 8'h00;
      cnt = 3'h0;
      rxByte = 8'h00;
   end
   // Drive on falling, sample on rising, in chosen order
   always @(negedge sclkLine)
   begin
      serialIn = bitOrder ? txByte[cnt] : txByte[3'h7 - cnt];
      cnt = cnt + 3'h1;
   end
   always @(posedge sclkLine)
   begin
      rxByte = bitOrder ? {serialOut, rxByte[7:1]} : {rxByte[6:0], serialOut};
      #100 serialIn = ~serialIn;
   end
   // External clock frame, 400 ns period, high outside frames
   task frame(input logic [7:0] b);
      txByte = b;
      repeat (8)
      begin
         extSclk = 1'b0;
         #200 extSclk = 1'b1;
         #200;
      end
   endtask
endmodule

// file: ssrd_tb.sv
// Testbench: serial port, word FIFO on the transmit source, far-side model
// Assumes ssrd_port, ssrd_fifo, model and monitor compiled before it
`timescale 1ns/100ps
module testbench;
   logic       clk;
   logic       rst;
   logic [1:0] mode;
   logic [2:0] clkSel;
   logic       order;
   logic [6:0] stb;
   logic [7:0] txData;
   logic [7:0] fInData;
   logic       fInValid;
   wire        fInReady, fOutValid, fOutReady, runQ, actQ, shiftQ, fullQ, freeQ, rxErrQ, txErrQ, irqQ;
   wire        sclkOut, sclkOe, serialIn, serialOut, extSclk, sclkLine;
   wire [7:0]  fOutData, rxBuf, farRx;
   int         err_total = 0;
   int         checks = 0;
   int         cycles = 0;
   int         i;
   int         acc;
   always #25 clk = ~clk;
   assign sclkLine = sclkOe ? sclkOut : extSclk;
   ssrd_fifo i_dut_fifo (.clk(clk), .rst(rst), .flush(stb[5]), .inData(fInData),
      .inValid(fInValid), .inReady(fInReady), .outData(fOutData), .outValid(fOutValid), .outReady(fOutReady));
   ssrd_port i_dut (.clk(clk), .rst(rst), .transferModeField(mode), .clockSelect(clkSel),
      .bitOrderSelect(order), .runSet(stb[0]), .runClear(stb[1]), .inhibitBit(stb[6]), .rxErrorClear(stb[2]),
      .rxBufferRead(stb[3]), .txBufferWrite(stb[4]), .txWriteData(txData), .txFifoValid(fOutValid),
      .txFifoData(fOutData), .txFifoReady(fOutReady), .runBit_q(runQ), .receiveBuffer_q(rxBuf),
      .transferActiveFlag_q(actQ), .shiftInProgressFlag_q(shiftQ), .receiveFullFlag_q(fullQ),
      .transmitBufferFreeFlag_q(freeQ), .receiveErrorFlag_q(rxErrQ), .transmitErrorFlag_q(txErrQ),
      .serialInterruptRequest_q(irqQ), .sclkIn(sclkLine), .sclkOut_q(sclkOut), .sclkOe_q(sclkOe),
      .serialIn(serialIn), .serialOut_q(serialOut));
   ssrd_far_model i_far (.sclkLine(sclkLine), .bitOrder(order), .serialOut(serialOut), .serialIn(serialIn),
      .extSclk(extSclk), .rxByte(farRx));
   ////////////////////////////////////////////////////////////////////////////////
   // Strobes: 0 run set, 1 run clear, 2 error clear, 3 read, 4 write, 5 flush, 6 inhibit
   task pulse(input int n);
      @(negedge clk);
      stb[n] = 1'b1;
      @(negedge clk);
      stb[n] = 1'b0;
   endtask
   task idle(input int n);
      repeat (n) @(negedge clk);
   endtask
   task chkBit(input string nm, input logic e, input logic g);
      checks++;
      if (g !== e)
      begin
         err_total++;
         $display("Error %s expected %b seen %b", nm, e, g);
      end
   endtask
   task chkByte(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task waitIrq;
      int n;
      n = 0;
      while (irqQ !== 1'b1 && n < 2000)
      begin
         @(posedge clk);
         #1 n++;
      end
      chkBit("irq", 1'b1, irqQ);
   endtask
   task end_sim;
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_total++;
         end_sim;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      rst = 1'b1;
      mode = 2'h0;
      clkSel = 3'h0;
      order = 1'b0;
      stb = 7'h00;
      txData = 8'h00;
      fInData = 8'h00;
      fInValid = 1'b0;
      idle(16);
      rst = 0;
      idle(2);
      chkBit("free", 1'b1, freeQ);
      chkBit("oe", 1'b0, sclkOe);
      chkBit("so", 1'b1, serialOut);
      mode = 2'h1;
      for (i = 0; i < 2; i++)
      begin
         order = i[0];
         i_far.txByte = i ? 8'h3C : 8'hA5;
         pulse(0);
         waitIrq;
         chkBit("act", 1'b1, actQ);
         chkByte("rxbuf", i ? 8'h3C : 8'hA5, rxBuf);
         chkBit("full", 1'b1, fullQ);
         idle(24);
         chkBit("park", 1'b1, sclkOut);
         chkBit("shift", 1'b0, shiftQ);
         pulse(1);
         pulse(3);
         chkBit("full", 1'b0, fullQ);
         idle(24);
         chkBit("act", 1'b0, actQ);
      end
      clkSel = 3'h7;
      order = 1'b0;
      pulse(0);
      i_far.frame(8'h5A);
      idle(4);
      chkBit("full", 1'b1, fullQ);
      i_far.frame(8'h81);
      idle(4);
      chkBit("receive_error_flag", 1'b1, rxErrQ);
      i_far.frame(8'hFF);
      idle(4);
      chkByte("rxbuf", 8'h5A, rxBuf);
      pulse(1);
      pulse(3);
      chkByte("rxbuf", 8'h81, rxBuf);
      pulse(2);
      chkBit("full", 1'b0, fullQ);
      i_far.frame(8'h00);
      idle(8);
      chkBit("act", 1'b0, actQ);
      pulse(6);
      clkSel = 3'h0;
      mode = 2'h2;
      txData = 8'hC3;
      pulse(4);
      i_far.txByte = 8'h96;
      pulse(0);
      waitIrq;
      chkByte("rxbuf", 8'h96, rxBuf);
      chkByte("far rx", 8'hC3, farRx);
      chkBit("free", 1'b1, freeQ);
      pulse(3);
      idle(24);
      chkBit("shift", 1'b0, shiftQ);
      chkBit("park", 1'b1, sclkOut);
      txData = 8'h00;
      pulse(4);
      waitIrq;
      chkByte("far rx", 8'h00, farRx);
      pulse(1);
      pulse(3);
      idle(24);
      chkBit("act", 1'b0, actQ);
      chkBit("so", 1'b1, serialOut);
      pulse(6);
      clkSel = 3'h7;
      pulse(0);
      i_far.frame(8'h24);
      idle(4);
      chkBit("transmit_error_flag", 1'b1, txErrQ);
      chkBit("so", 1'b1, serialOut);
      chkByte("rxbuf", 8'h24, rxBuf);
      pulse(3);
      pulse(6);
      chkBit("transmit_error_flag", 1'b0, txErrQ);
      chkBit("run", 1'b0, runQ);
      mode = 2'h0;
      acc = 0;
      for (i = 0; i < 12; i++)
      begin
         @(negedge clk);
         fInData = acc[7:0];
         fInValid = 1'b1;
         if (fInReady === 1'b1)
            acc++;
      end
      @(negedge clk);
      fInValid = 1'b0;
      chkBit("fifo refuses", 1'b0, fInReady);
      chkBit("fifo holds", 1'b1, fOutValid);
      chkByte("fifo count", 8'h09, acc[7:0]);
      chkByte("fifo head", 8'h01, fOutData);
      pulse(5);
      chkBit("fifo empty", 1'b0, fOutValid);
      chkBit("fifo ready", 1'b1, fInReady);
      end_sim;
   end
endmodule
bind ssrd_port ssrd_port_monitor #(.DIV_HALF(DIV_HALF)) i_mon (.clk(clk), .rst(rst),
   .transferModeField(transferModeField), .clockSelect(clockSelect), .rxBufferRead(rxBufferRead),
   .inhibitBit(inhibitBit), .runBit_q(runBit_q), .receiveBuffer_q(receiveBuffer_q),
   .transferActiveFlag_q(transferActiveFlag_q), .receiveFullFlag_q(receiveFullFlag_q),
   .receiveErrorFlag_q(receiveErrorFlag_q), .transmitErrorFlag_q(transmitErrorFlag_q),
   .serialInterruptRequest_q(serialInterruptRequest_q), .sclkOe_q(sclkOe_q), .serialOut_q(serialOut_q));
